//--- rtl/tto_map.vh
// Purpose: Register offsets, field positions and reset values for the
//          transceiver test override register bank.
// Assumes: 8-bit registers reached over a plain strobe port.
// Notes:   Definitions only.
`ifndef TTO_MAP_VH
`define TTO_MAP_VH
`define TTO_ADDR_W 7
`define TTO_OFS_PROBE 7'h24
`define TTO_OFS_TEST_CTRL 7'h25
`define TTO_OFS_COUPLER 7'h26
`define TTO_OFS_STAGE 7'h27
`define TTO_RST_PROBE 8'h00
`define TTO_RST_TEST_CTRL 8'h40
`define TTO_RST_COUPLER 8'h00
`define TTO_RST_STAGE 8'h00
`define TTO_BIT_FCOMP 7
`define TTO_BIT_DITHER 6
`define TTO_BIT_ADC_OUT 5
`define TTO_BIT_CHOP 4
`define TTO_BIT_SHAPE 3
`define TTO_BIT_VCM 2
`define TTO_BIT_FILT_CONN 1
`define TTO_BIT_ADC_CONN 0
`define TTO_BIT_VGA_OVR 3
`define TTO_BIT_AC1 2
`define TTO_BIT_PD 3
`define TTO_BIT_MODE2 2
`define TTO_ROT_SEQ_A 2'h0
`define TTO_ROT_SEQ_B 2'h1
`define TTO_ROT_HOLD 2'h2
`define TTO_ROT_ALT 2'h3
`define TTO_LSB_AC2 0
`define TTO_LSB_STG1 4
`define TTO_LSB_STG2 2
`define TTO_LSB_STG3 0
`define TTO_RST_PD 1'b1
`define TTO_RST_MODE 3'h4
`define TTO_RST_DITHER 1'b1
`endif

//--- rtl/tto_rotator.v
// Purpose: Steps the ADC input rotation position.
// Assumes: step is a one-cycle pulse from the ADC sample timing.
// Notes:   Position restarts at 00 whenever the mode changes.
`timescale 1ns/10ps
`include "tto_map.vh"
module tto_rotator (
  input wire clk_sys, // System clock.
  input wire reset_n, // Asynchronous reset, active low.
  input wire [1:0] mode, // Rotation mode field.
  input wire step, // Advance to next position.
  output reg [1:0] pos_r // Current input position.
);
  reg [1:0] mode_r;
  reg [1:0] pos_nxt;

  always @* begin
    pos_nxt = pos_r;
    if (mode != mode_r) begin
      pos_nxt = 2'h0;
    end else if (step) begin
      case (mode)
        `TTO_ROT_SEQ_A: pos_nxt = pos_r + 2'h1;
        `TTO_ROT_SEQ_B: begin
          case (pos_r)
            2'h0: pos_nxt = 2'h2;
            2'h2: pos_nxt = 2'h3;
            2'h3: pos_nxt = 2'h1;
            default: pos_nxt = 2'h0;
          endcase
        end
        `TTO_ROT_HOLD: pos_nxt = 2'h0;
        default: pos_nxt = (pos_r == 2'h0) ? 2'h2 : 2'h0;
      endcase
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= 2'h0;
      pos_r <= 2'h0;
    end else begin
      mode_r <= mode;
      pos_r <= pos_nxt;
    end
  end
endmodule

//--- rtl/tto_regs.v
// Purpose: Test override register bank of a narrowband RF transceiver.
// Assumes: One clock; pin-side inputs are synchronised here.
// Notes:   Unmapped reads return zero; unmapped writes are ignored.
`timescale 1ns/10ps
`include "tto_map.vh"
module tto_regs (
  input wire clk_sys, // System clock, 50 MHz.
  input wire reset_n, // Asynchronous reset, active low.
  input wire [6:0] reg_addr, // Register address.
  input wire [7:0] reg_wdata, // Write data.
  input wire reg_wr, // Write strobe.
  input wire reg_rd, // Read strobe.
  output reg [7:0] reg_rdata_r, // Read data, cycle after strobe.
  input wire [3:0] interface_bits, // Interface register bits 3:0.
  input wire fcomp_in, // Frequency comparator from detector.
  input wire adc_sample_in, // ADC sample bit.
  input wire adc_clk_in, // ADC sampling clock.
  input wire lock_in, // Normal synthesizer status value.
  input wire serial_data_in, // Normal serial data output value.
  input wire data_clock_in, // Normal data clock output value.
  input wire adc_step, // Rotation advance pulse, same clock.
  input wire [1:0] agc_ac2_in, // Automatic second coupler gain.
  input wire agc_ac1_in, // Automatic first coupler gain.
  input wire [5:0] agc_stage_in, // Automatic stage gains 1,2,3.
  output reg filter_probe_connect_r, // Probe on image filter inputs.
  output reg adc_probe_connect_r, // Probe on ADC inputs.
  output reg analog_probe_powerdown_r, // Probe power-down.
  output reg [2:0] probe_mode_r, // Probe test mode.
  output reg fcomp_out_r, // Gated frequency comparator output.
  output reg ds_clk_dither_en_r, // Delta-sigma clock dither enable.
  output reg lock_pin_r, // Synthesizer status pin value.
  output reg serial_data_pin_r, // Serial data pin value.
  output reg data_clock_pin_r, // Data clock pin value.
  output reg integrator_chop_off_r, // Disable integrator chopping.
  output reg shaping_off_r, // Disable feedback mismatch shaping.
  output reg common_mode_rotation_off_r, // Stop common-mode rotation.
  output reg [1:0] adc_rot_pos_r, // ADC input rotation position.
  output reg coupler1_gain_val_r, // First coupler gain to VGA.
  output reg [1:0] coupler2_gain_val_r, // Second coupler gain to VGA.
  output reg [1:0] gain_stage1_val_r, // Stage 1 gain to VGA.
  output reg [1:0] gain_stage2_val_r, // Stage 2 gain to VGA.
  output reg [1:0] gain_stage3_val_r // Stage 3 gain to VGA.
);
  localparam NSYNC = 7;
  localparam SYNC_PD = 6;
  localparam SYNC_MODE = 3;
  localparam SYNC_FCOMP = 2;
  localparam SYNC_SAMPLE = 1;
  localparam SYNC_ACLK = 0;
  reg [7:0] probe_ctrl_r;
  reg [7:0] test_ctrl_r;
  reg [7:0] coupler_r;
  reg [7:0] stage_r;
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;
  reg [7:0] rdata_nxt;
  wire [NSYNC-1:0] pin_raw;
  wire [1:0] rot_pos;
  wire probe_on;
  wire ovr_on;
  reg filter_probe_connect_nxt;
  reg adc_probe_connect_nxt;
  reg analog_probe_powerdown_nxt;
  reg [2:0] probe_mode_nxt;
  reg fcomp_out_nxt;
  reg ds_clk_dither_en_nxt;
  reg lock_pin_nxt;
  reg serial_data_pin_nxt;
  reg data_clock_pin_nxt;
  reg integrator_chop_off_nxt;
  reg shaping_off_nxt;
  reg common_mode_rotation_off_nxt;
  reg [1:0] adc_rot_pos_nxt;
  reg coupler1_gain_val_nxt;
  reg [1:0] coupler2_gain_val_nxt;
  reg [1:0] gain_stage1_val_nxt;
  reg [1:0] gain_stage2_val_nxt;
  reg [1:0] gain_stage3_val_nxt;

  assign pin_raw = {interface_bits, fcomp_in, adc_sample_in, adc_clk_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // Register writes; reserved bits are stored as written.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      probe_ctrl_r <= `TTO_RST_PROBE;
      test_ctrl_r <= `TTO_RST_TEST_CTRL;
      coupler_r <= `TTO_RST_COUPLER;
      stage_r <= `TTO_RST_STAGE;
    end else if (reg_wr) begin
      case (reg_addr)
        `TTO_OFS_PROBE: probe_ctrl_r <= reg_wdata;
        `TTO_OFS_TEST_CTRL: test_ctrl_r <= reg_wdata;
        `TTO_OFS_COUPLER: coupler_r <= reg_wdata;
        `TTO_OFS_STAGE: stage_r <= reg_wdata;
        default: probe_ctrl_r <= probe_ctrl_r;
      endcase
    end
  end

  always @* begin
    case (reg_addr)
      `TTO_OFS_PROBE: rdata_nxt = probe_ctrl_r;
      `TTO_OFS_TEST_CTRL: rdata_nxt = test_ctrl_r;
      `TTO_OFS_COUPLER: rdata_nxt = coupler_r;
      `TTO_OFS_STAGE: rdata_nxt = stage_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  tto_rotator u_rot (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .mode(test_ctrl_r[1:0]),
    .step(adc_step),
    .pos_r(rot_pos)
  );

  assign probe_on = probe_ctrl_r[`TTO_BIT_FILT_CONN] |
                    probe_ctrl_r[`TTO_BIT_ADC_CONN];
  assign ovr_on = coupler_r[`TTO_BIT_VGA_OVR];

  // With no connect bit set the probe stays powered down.
  always @* begin
    filter_probe_connect_nxt = probe_ctrl_r[`TTO_BIT_FILT_CONN];
    adc_probe_connect_nxt = probe_ctrl_r[`TTO_BIT_ADC_CONN];
    if (probe_on) begin
      analog_probe_powerdown_nxt = sync2_r[SYNC_PD];
      probe_mode_nxt = sync2_r[SYNC_MODE +: 3];
    end else begin
      analog_probe_powerdown_nxt = 1'b1;
      probe_mode_nxt = {1'b1, sync2_r[SYNC_MODE +: 2]};
    end
  end

  always @* begin
    fcomp_out_nxt = test_ctrl_r[`TTO_BIT_FCOMP] &
                    sync2_r[SYNC_FCOMP];
    ds_clk_dither_en_nxt = test_ctrl_r[`TTO_BIT_DITHER];
    integrator_chop_off_nxt = test_ctrl_r[`TTO_BIT_CHOP];
    shaping_off_nxt = test_ctrl_r[`TTO_BIT_SHAPE];
    common_mode_rotation_off_nxt = test_ctrl_r[`TTO_BIT_VCM];
    adc_rot_pos_nxt = rot_pos;
  end

  // In ADC test mode the sample bit drives the status and serial data pins.
  always @* begin
    if (test_ctrl_r[`TTO_BIT_ADC_OUT]) begin
      lock_pin_nxt = sync2_r[SYNC_SAMPLE];
      serial_data_pin_nxt = sync2_r[SYNC_SAMPLE];
      data_clock_pin_nxt = sync2_r[SYNC_ACLK];
    end else begin
      lock_pin_nxt = lock_in;
      serial_data_pin_nxt = serial_data_in;
      data_clock_pin_nxt = data_clock_in;
    end
  end

  // Manual gains replace the automatic ones only while override is set.
  always @* begin
    if (ovr_on) begin
      coupler1_gain_val_nxt = coupler_r[`TTO_BIT_AC1];
      coupler2_gain_val_nxt = coupler_r[`TTO_LSB_AC2 +: 2];
      gain_stage1_val_nxt = stage_r[`TTO_LSB_STG1 +: 2];
      gain_stage2_val_nxt = stage_r[`TTO_LSB_STG2 +: 2];
      gain_stage3_val_nxt = stage_r[`TTO_LSB_STG3 +: 2];
    end else begin
      coupler1_gain_val_nxt = agc_ac1_in;
      coupler2_gain_val_nxt = agc_ac2_in;
      gain_stage1_val_nxt = agc_stage_in[`TTO_LSB_STG1 +: 2];
      gain_stage2_val_nxt = agc_stage_in[`TTO_LSB_STG2 +: 2];
      gain_stage3_val_nxt = agc_stage_in[`TTO_LSB_STG3 +: 2];
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      filter_probe_connect_r <= 1'b0;
    end else begin
      filter_probe_connect_r <= filter_probe_connect_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      adc_probe_connect_r <= 1'b0;
    end else begin
      adc_probe_connect_r <= adc_probe_connect_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      analog_probe_powerdown_r <= `TTO_RST_PD;
    end else begin
      analog_probe_powerdown_r <= analog_probe_powerdown_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      probe_mode_r <= `TTO_RST_MODE;
    end else begin
      probe_mode_r <= probe_mode_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fcomp_out_r <= 1'b0;
    end else begin
      fcomp_out_r <= fcomp_out_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ds_clk_dither_en_r <= `TTO_RST_DITHER;
    end else begin
      ds_clk_dither_en_r <= ds_clk_dither_en_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lock_pin_r <= 1'b0;
    end else begin
      lock_pin_r <= lock_pin_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serial_data_pin_r <= 1'b0;
    end else begin
      serial_data_pin_r <= serial_data_pin_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_clock_pin_r <= 1'b0;
    end else begin
      data_clock_pin_r <= data_clock_pin_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      integrator_chop_off_r <= 1'b0;
    end else begin
      integrator_chop_off_r <= integrator_chop_off_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shaping_off_r <= 1'b0;
    end else begin
      shaping_off_r <= shaping_off_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      common_mode_rotation_off_r <= 1'b0;
    end else begin
      common_mode_rotation_off_r <= common_mode_rotation_off_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      adc_rot_pos_r <= 2'h0;
    end else begin
      adc_rot_pos_r <= adc_rot_pos_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      coupler1_gain_val_r <= 1'b0;
    end else begin
      coupler1_gain_val_r <= coupler1_gain_val_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      coupler2_gain_val_r <= 2'h0;
    end else begin
      coupler2_gain_val_r <= coupler2_gain_val_nxt;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gain_stage1_val_r <= 2'h0;
      gain_stage2_val_r <= 2'h0;
      gain_stage3_val_r <= 2'h0;
    end else begin
      gain_stage1_val_r <= gain_stage1_val_nxt;
      gain_stage2_val_r <= gain_stage2_val_nxt;
      gain_stage3_val_r <= gain_stage3_val_nxt;
    end
  end
endmodule

//--- verif/tto_regs_props.sv
// Purpose: Port assertions for the test override register bank.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Attached to every instance of the bank by bind.
`timescale 1ns/10ps
`include "tto_map.vh"
module tto_regs_props (
  input wire clk_sys, // Clock.
  input wire reset_n, // Reset.
  input wire [6:0] reg_addr, // Address.
  input wire reg_rd, // Read strobe.
  input wire [7:0] reg_rdata_r, // Read data.
  input wire [3:0] interface_bits, // Interface bits.
  input wire fcomp_in, // Comparator in.
  input wire lock_in, // Normal status.
  input wire data_clock_in, // Normal clock.
  input wire adc_step, // Rotation step.
  input wire [1:0] agc_ac2_in, // Auto gain 2.
  input wire agc_ac1_in, // Auto gain 1.
  input wire filter_probe_connect_r, // Filter probe.
  input wire adc_probe_connect_r, // ADC probe.
  input wire analog_probe_powerdown_r, // Probe off.
  input wire [2:0] probe_mode_r, // Probe mode.
  input wire fcomp_out_r, // Comparator out.
  input wire ds_clk_dither_en_r, // Dither.
  input wire lock_pin_r, // Status pin.
  input wire serial_data_pin_r, // Data pin.
  input wire data_clock_pin_r, // Clock pin.
  input wire integrator_chop_off_r, // Chop off.
  input wire shaping_off_r, // Shaping off.
  input wire common_mode_rotation_off_r, // Rotation off.
  input wire [1:0] adc_rot_pos_r, // Position.
  input wire coupler1_gain_val_r, // Gain 1.
  input wire [1:0] coupler2_gain_val_r // Gain 2.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire conn = filter_probe_connect_r | adc_probe_connect_r;
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  property p_probe_off;
    !conn |-> analog_probe_powerdown_r && probe_mode_r[2];
  endproperty
  a_probe_off: assert property (p_probe_off) else $error("probe on");
  property p_probe_on;
    ($stable(interface_bits) && conn)[*4]
      |-> {analog_probe_powerdown_r, probe_mode_r} == interface_bits;
  endproperty
  a_probe_on: assert property (p_probe_on) else $error("probe bits");
  property p_fcomp;
    (!fcomp_in)[*4] |-> !fcomp_out_r;
  endproperty
  a_fcomp: assert property (p_fcomp) else $error("comparator out");
  property p_dither_rst;
    !$past(reset_n) |-> ds_clk_dither_en_r;
  endproperty
  a_dither_rst: assert property (p_dither_rst) else $error("dither");
  property p_pins;
    lock_pin_r != serial_data_pin_r |-> lock_pin_r == $past(lock_in)
      && data_clock_pin_r == $past(data_clock_in);
  endproperty
  a_pins: assert property (p_pins) else $error("pin source");
  property p_ctrl_rb;
    s_rd(`TTO_OFS_TEST_CTRL) |=> {reg_rdata_r[6], reg_rdata_r[4:2]} ==
      {ds_clk_dither_en_r, integrator_chop_off_r, shaping_off_r,
       common_mode_rotation_off_r};
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("ctrl bits");
  property p_ovr;
    s_rd(`TTO_OFS_COUPLER) |=> {coupler1_gain_val_r, coupler2_gain_val_r}
      == (reg_rdata_r[3] ? reg_rdata_r[2:0]
          : {$past(agc_ac1_in), $past(agc_ac2_in)});
  endproperty
  a_ovr: assert property (p_ovr) else $error("coupler gain");
  property p_rot;
    adc_rot_pos_r != $past(adc_rot_pos_r) && adc_rot_pos_r != 2'h0
      |-> $past(adc_step, 2);
  endproperty
  a_rot: assert property (p_rot) else $error("rotation step");
endmodule
bind tto_regs tto_regs_props i_props (.*);

//--- verif/tto_regs_tb.sv
// Purpose: Self-checking bench for the test override register bank.
// Assumes: Register strobes driven just after rising edges.
// Notes: Each scenario task checks its own results.
`timescale 1ns/10ps
`include "tto_map.vh"
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("BAD %s exp %0h got %0h", n, e, g); \
  end \
end
module tto_regs_tb;
  int num_errors = 0;
  int cmp_count = 0;
  logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, fcomp_in = 0;
  logic adc_sample_in = 0, adc_clk_in = 0, lock_in = 0, adc_step = 0;
  logic serial_data_in = 0, data_clock_in = 0, agc_ac1_in = 1;
  logic [6:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata_r;
  logic [3:0] interface_bits = 0;
  logic [1:0] agc_ac2_in = 2'h2, coupler2_gain_val_r, adc_rot_pos_r;
  logic [5:0] agc_stage_in = 6'h1B;
  logic [2:0] probe_mode_r;
  logic [1:0] gain_stage1_val_r, gain_stage2_val_r, gain_stage3_val_r;
  logic filter_probe_connect_r, adc_probe_connect_r, fcomp_out_r;
  logic analog_probe_powerdown_r, ds_clk_dither_en_r, lock_pin_r;
  logic serial_data_pin_r, data_clock_pin_r, integrator_chop_off_r;
  logic shaping_off_r, common_mode_rotation_off_r, coupler1_gain_val_r;
  logic [9:0] pt [5] = '{10'h05D, 10'h255, 10'h1AA, 10'h333, 10'h0AE};
  logic [7:0] rs [4] = '{8'h6C, 8'hB4, 8'h00, 8'h88};
  tto_regs i_dut (.*);
  always #10 clk_sys = ~clk_sys;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input [6:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input [6:0] a, input [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata_r)
  endtask
  task automatic t_reset;
    `CHK("dither", 1'b1, ds_clk_dither_en_r)
    `CHK("probe", 4'hC, {analog_probe_powerdown_r, probe_mode_r})
    rd(`TTO_OFS_TEST_CTRL, 8'h40);
    rd(`TTO_OFS_COUPLER, 8'h00);
    rd(`TTO_OFS_STAGE, 8'h00);
    rd(7'h30, 8'h00);
  endtask
  task automatic t_ctrl;
    wr(`TTO_OFS_TEST_CTRL, 8'h1C);
    tick(1);
    `CHK("ctrl", 4'h7, {ds_clk_dither_en_r, integrator_chop_off_r, shaping_off_r, common_mode_rotation_off_r})
    rd(`TTO_OFS_TEST_CTRL, 8'h1C);
    @(posedge clk_sys);
    fcomp_in <= 1'b1;
    wr(`TTO_OFS_TEST_CTRL, 8'h80);
    tick(4);
    `CHK("fcomp", 1'b1, fcomp_out_r)
    wr(`TTO_OFS_TEST_CTRL, 8'h00);
    tick(2);
    `CHK("fcomp", 1'b0, fcomp_out_r)
  endtask
  task automatic t_pins;
    @(posedge clk_sys);
    data_clock_in <= 1'b1;
    lock_in <= 1'b1;
    adc_sample_in <= 1'b1;
    tick(2);
    `CHK("pins", 3'h5, {lock_pin_r, serial_data_pin_r, data_clock_pin_r})
    wr(`TTO_OFS_TEST_CTRL, 8'h20);
    tick(4);
    `CHK("pins", 3'h6, {lock_pin_r, serial_data_pin_r, data_clock_pin_r})
    @(posedge clk_sys);
    adc_sample_in <= 1'b0;
    adc_clk_in <= 1'b1;
    tick(4);
    `CHK("pins", 3'h1, {lock_pin_r, serial_data_pin_r, data_clock_pin_r})
  endtask
  task automatic t_probe;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      interface_bits <= pt[i][7:4];
      wr(7'h24, {6'h00, pt[i][9:8]});
      tick(4);
      `CHK("probe", pt[i][3:0], {analog_probe_powerdown_r, probe_mode_r})
      `CHK("conn", pt[i][9:8], {filter_probe_connect_r, adc_probe_connect_r})
    end
  endtask
  task automatic t_rot;
    for (int m = 0; m < 4; m++) begin
      wr(`TTO_OFS_TEST_CTRL, m[7:0]);
      tick(2);
      for (int k = 0; k < 4; k++) begin
        @(posedge clk_sys);
        adc_step <= 1'b1;
        @(posedge clk_sys);
        adc_step <= 1'b0;
        tick(2);
        `CHK("rot", rs[m][7-2*k -: 2], adc_rot_pos_r)
      end
    end
  endtask
  task automatic t_ovr;
    wr(`TTO_OFS_COUPLER, 8'h00);
    tick(1);
    `CHK("gain", 9'h19B, {coupler1_gain_val_r, coupler2_gain_val_r, gain_stage1_val_r, gain_stage2_val_r, gain_stage3_val_r})
    wr(`TTO_OFS_STAGE, 8'h24);
    wr(`TTO_OFS_COUPLER, 8'h0B);
    tick(1);
    `CHK("gain", 9'h0E4, {coupler1_gain_val_r, coupler2_gain_val_r, gain_stage1_val_r, gain_stage2_val_r, gain_stage3_val_r})
    rd(`TTO_OFS_COUPLER, 8'h0B);
    wr(`TTO_OFS_COUPLER, 8'h0C);
    tick(1);
    `CHK("ac1", 3'h4, {coupler1_gain_val_r, coupler2_gain_val_r})
    rd(`TTO_OFS_STAGE, 8'h24);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    tick(1);
    t_reset();
    t_ctrl();
    t_pins();
    t_probe();
    t_rot();
    t_ovr();
    end_sim();
  end
endmodule
